/* File: hw/cfd_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock, 32-bit Avalon-MM register bus
// Notes: byte offsets, one aligned word per register
`ifndef CFD_MAP_SVH
`define CFD_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CFD_OFS_CLOCK 8'h00
`define CFD_OFS_FRAC 8'h04
`define CFD_OFS_SENS 8'h08
`define CFD_OFS_LEVEL 8'h0c
`define CFD_OFS_MPX 8'h10
`define CFD_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// field positions (low bit of each field)
// ----------------------------------------------------------------
`define CFD_POS_TURBO 15
`define CFD_POS_PLL_DIV 11
`define CFD_POS_FRAC_A 0
`define CFD_POS_FRAC_B 4
`define CFD_POS_SENS_MPX 1
`define CFD_POS_SENS_RDS 4
`define CFD_POS_DEV 13
`define CFD_POS_LEN 6
`define CFD_POS_OFS 4
`define CFD_POS_TRIG 0
`define CFD_POS_DELAY 9
`define CFD_POS_SUPP 6
`define CFD_POS_PENDING 0
`define CFD_POS_APPLIED_PLL 8

// ----------------------------------------------------------------
// reset values of the fields
// ----------------------------------------------------------------
`define CFD_RST_TURBO 1'h0
`define CFD_RST_PLL_DIV 4'ha
`define CFD_RST_FRAC_A 4'h3
`define CFD_RST_FRAC_B 4'h2
`define CFD_RST_SENS_MPX 3'h6
`define CFD_RST_SENS_RDS 3'h6
`define CFD_RST_DEV 2'h0
`define CFD_RST_LEN 2'h1
`define CFD_RST_OFS 2'h0
`define CFD_RST_TRIG 4'h0
`define CFD_RST_DELAY 2'h1
`define CFD_RST_SUPP 3'h3

// ----------------------------------------------------------------
// timing: one processing period of 304 kHz
// ----------------------------------------------------------------
`define CFD_CLK_PS 50000
`define CFD_PERIOD_PS 3289474
`define CFD_PERIOD_CYC (`CFD_PERIOD_PS / `CFD_CLK_PS)

`endif

/* File: hw/cfd_pkg.sv */
// Purpose: types shared by the field decoder files
// Assumes: nothing beyond the map header
// Notes: written fields and decoded settings travel as packed structs
package cfd_pkg;

  // --------------------------------------------------------------
  // raw fields as written by software
  // --------------------------------------------------------------
  typedef struct packed {
    logic turbo;
    logic [3:0] pll_div;
    logic [3:0] frac_a;
    logic [3:0] frac_b;
    logic [2:0] sens_mpx;
    logic [2:0] sens_rds;
    logic [1:0] dev;
    logic [1:0] len;
    logic [1:0] ofs;
    logic [3:0] trig;
    logic [1:0] delay;
    logic [2:0] supp;
  } cfd_fields_s;

  // --------------------------------------------------------------
  // decoded working constants
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pll_factor;       // 93..181
    logic [4:0] frac_a_half;      // half steps, 12..27
    logic [4:0] frac_b_half;
    logic [10:0] mpx_full_mv;     // 0 dB level in mV
    logic [10:0] rds_full_mv;
    logic [9:0] dev_limit_100hz;  // 430..650
    logic [3:0] blank_len;        // 304 kHz periods
    logic signed [2:0] blank_ofs; // -2..1 periods
    logic blank_enable;
    logic [6:0] blank_trigger;    // 7 fraction bits
    logic [2:0] multiplex_blanking_delay;        // 2..5 periods
    logic [2:0] pulse_len;        // 0..7
    logic [2:0] stretch;          // pulse_len - 1
    logic stretch_valid;
  } cfd_setting_s;

endpackage

/* File: hw/cfd_period_tick.sv */
// Purpose: one-cycle enable at the 304 kHz processing rate
// Assumes: runs on the system clock
// Notes: period count fixed by the map header
`timescale 1ns/10ps
`default_nettype none
`include "cfd_map.svh"

module cfd_period_tick (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // enable out
  output logic tick
);
  import cfd_pkg::*;

  localparam logic [6:0] LAST = 7'(`CFD_PERIOD_CYC - 1);

  logic [6:0] count_reg;
  logic tick_reg;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else if (count_reg == LAST) begin
      count_reg <= 7'h00;
      tick_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + 7'h01;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

/* File: hw/cfd_top.sv */
// Purpose: decode clock and interference absorber fields into constants
// Assumes: 20 MHz clock, synchronous active-low reset, Avalon-MM slave
// Notes: decoded constants change only at a processing period boundary
//
// Notes on behaviour
// - Pll divider codes map to factors 93..181, default 1010 giving 154.
// - Fraction codes 0..7 are 10..13.5, 8..f are 6..9.5, defaults 3 and 2.
// - Sensitivity codes pick 0 dB levels of 410..1387 mV, default 110.
// - The 2-bit deviation limit gives 43, 48.5, 58 or 65 kHz, default 00.
// - The level blanking length is 9, 11, 13 or 15 periods, default 01.
// - The level blanking offset is -2, -1, 0 or 1 periods, default 00.
// - Trigger code 0000 turns level blanking off, others give 0.02..0.5.
// - Delay codes 10, 11, 00, 01 give 2, 3, 4, 5 periods, default 01.
// - Suppression picks pulse length 0..7; stretch is one less, none at 0.
`timescale 1ns/10ps
`default_nettype none
`include "cfd_map.svh"

module cfd_top (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // decoded constants
  output cfd_pkg::cfd_setting_s setting,
  output logic setting_strobe
);
  import cfd_pkg::*;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] pll_factor(input logic [3:0] c);
    logic [7:0] f;
    f = 8'd93;
    unique case (c)
      4'h0: f = 8'd93;
      4'h1: f = 8'd99;
      4'h2: f = 8'd106;
      4'h3: f = 8'd113;
      4'h4: f = 8'd121;
      4'h5: f = 8'd126;
      4'h6: f = 8'd132;
      4'h7: f = 8'd137;
      4'h8: f = 8'd143;
      4'h9: f = 8'd148;
      4'ha: f = 8'd154;
      4'hb: f = 8'd159;
      4'hc: f = 8'd165;
      4'hd: f = 8'd170;
      4'he: f = 8'd176;
      4'hf: f = 8'd181;
    endcase
    return f;
  endfunction

  // signed nibble plus 20 half steps
  function automatic logic [4:0] frac_half(input logic [3:0] c);
    return c[3] ? (5'd4 + {1'b0, c}) : (5'd20 + {1'b0, c});
  endfunction

  function automatic logic [10:0] sens_mv(input logic [2:0] c);
    logic [10:0] v;
    v = 11'd410;
    unique case (c)
      3'h0: v = 11'd410;
      3'h1: v = 11'd493;
      3'h2: v = 11'd587;
      3'h3: v = 11'd700;
      3'h4: v = 11'd833;
      3'h5: v = 11'd1000;
      3'h6: v = 11'd1188;
      3'h7: v = 11'd1387;
    endcase
    return v;
  endfunction

  function automatic logic [9:0] dev_limit(input logic [1:0] c);
    logic [9:0] v;
    v = 10'd430;
    unique case (c)
      2'h0: v = 10'd430;
      2'h1: v = 10'd485;
      2'h2: v = 10'd580;
      2'h3: v = 10'd650;
    endcase
    return v;
  endfunction

  function automatic logic [6:0] trig_level(input logic [3:0] c);
    logic [6:0] v;
    v = 7'h00;
    unique case (c)
      4'h0: v = 7'h00;
      4'h1: v = 7'h02;
      4'h2: v = 7'h03;
      4'h3: v = 7'h04;
      4'h4: v = 7'h05;
      4'h5: v = 7'h06;
      4'h6: v = 7'h08;
      4'h7: v = 7'h0a;
      4'h8: v = 7'h0d;
      4'h9: v = 7'h10;
      4'ha: v = 7'h14;
      4'hb: v = 7'h1a;
      4'hc: v = 7'h20;
      4'hd: v = 7'h28;
      4'he: v = 7'h34;
      4'hf: v = 7'h40;
    endcase
    return v;
  endfunction

  function automatic cfd_setting_s decode(input cfd_fields_s f);
    cfd_setting_s s;
    logic [2:0] plen;
    s.pll_factor = pll_factor(f.pll_div);
    s.frac_a_half = frac_half(f.frac_a);
    s.frac_b_half = frac_half(f.frac_b);
    s.mpx_full_mv = sens_mv(f.sens_mpx);
    s.rds_full_mv = sens_mv(f.sens_rds);
    s.dev_limit_100hz = dev_limit(f.dev);
    s.blank_len = {1'b0, f.len, 1'b1} + 4'd8;
    s.blank_ofs = $signed({1'b0, f.ofs}) - 3'sd2;
    s.blank_enable = (f.trig != 4'h0);
    s.blank_trigger = trig_level(f.trig);
    s.multiplex_blanking_delay = 3'd2 + {1'b0, ~f.delay[1], f.delay[0]};
    plen = {~f.supp[2], f.supp[1], ~f.supp[0]};
    s.pulse_len = plen;
    s.stretch = (plen == 3'h0) ? 3'h0 : plen - 3'h1;
    s.stretch_valid = (plen != 3'h0);
    return s;
  endfunction

  // ----------------------------------------------------------------
  // written fields and period enable
  // ----------------------------------------------------------------
  localparam cfd_fields_s FIELDS_RST = '{
    turbo: `CFD_RST_TURBO, pll_div: `CFD_RST_PLL_DIV,
    frac_a: `CFD_RST_FRAC_A, frac_b: `CFD_RST_FRAC_B,
    sens_mpx: `CFD_RST_SENS_MPX, sens_rds: `CFD_RST_SENS_RDS,
    dev: `CFD_RST_DEV, len: `CFD_RST_LEN, ofs: `CFD_RST_OFS,
    trig: `CFD_RST_TRIG, delay: `CFD_RST_DELAY, supp: `CFD_RST_SUPP};

  cfd_fields_s fields_reg;
  cfd_setting_s setting_reg;
  logic strobe_reg;
  logic pending_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic tick;
  logic [15:0] wdata;
  logic [15:0] mask;
  logic wr_take;

  cfd_period_tick u_tick (
    .clock(clock),
    .resetn(resetn),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then accept
  // ----------------------------------------------------------------
  assign wr_take = write && !waitrequest_reg;
  assign mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wdata = writedata[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old);
    return (old & ~mask) | (wdata & mask);
  endfunction

  function automatic logic [15:0] reg_view(input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case ({a[7:2], 2'b00})
      `CFD_OFS_CLOCK: begin
        v[`CFD_POS_TURBO] = fields_reg.turbo;
        v[`CFD_POS_PLL_DIV +: 4] = fields_reg.pll_div;
      end
      `CFD_OFS_FRAC: begin
        v[`CFD_POS_FRAC_A +: 4] = fields_reg.frac_a;
        v[`CFD_POS_FRAC_B +: 4] = fields_reg.frac_b;
      end
      `CFD_OFS_SENS: begin
        v[`CFD_POS_SENS_MPX +: 3] = fields_reg.sens_mpx;
        v[`CFD_POS_SENS_RDS +: 3] = fields_reg.sens_rds;
      end
      `CFD_OFS_LEVEL: begin
        v[`CFD_POS_DEV +: 2] = fields_reg.dev;
        v[`CFD_POS_LEN +: 2] = fields_reg.len;
        v[`CFD_POS_OFS +: 2] = fields_reg.ofs;
        v[`CFD_POS_TRIG +: 4] = fields_reg.trig;
      end
      `CFD_OFS_MPX: begin
        v[`CFD_POS_DELAY +: 2] = fields_reg.delay;
        v[`CFD_POS_SUPP +: 3] = fields_reg.supp;
      end
      `CFD_OFS_STATUS: begin
        v[`CFD_POS_PENDING] = pending_reg;
        v[`CFD_POS_APPLIED_PLL +: 8] = setting_reg.pll_factor;
      end
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // current register contents with the enabled write lanes merged in
  logic [15:0] merged;

  always_comb begin
    merged = merge(reg_view(address));
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end else if ((read || write) && waitrequest_reg) begin
      waitrequest_reg <= 1'b0;
      readdata_reg <= {16'h0000, reg_view(address)};
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // field writes; unmapped and status writes are dropped
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fields_reg <= FIELDS_RST;
    end else if (wr_take) begin
      unique case ({address[7:2], 2'b00})
        `CFD_OFS_CLOCK: begin
          // stored only; decode stays on the normal-speed table
          fields_reg.turbo <= merged[`CFD_POS_TURBO];
          fields_reg.pll_div <= merged[`CFD_POS_PLL_DIV +: 4];
        end
        `CFD_OFS_FRAC: begin
          fields_reg.frac_a <= merged[`CFD_POS_FRAC_A +: 4];
          fields_reg.frac_b <= merged[`CFD_POS_FRAC_B +: 4];
        end
        `CFD_OFS_SENS: begin
          fields_reg.sens_mpx <= merged[`CFD_POS_SENS_MPX +: 3];
          fields_reg.sens_rds <= merged[`CFD_POS_SENS_RDS +: 3];
        end
        `CFD_OFS_LEVEL: begin
          fields_reg.dev <= merged[`CFD_POS_DEV +: 2];
          fields_reg.len <= merged[`CFD_POS_LEN +: 2];
          fields_reg.ofs <= merged[`CFD_POS_OFS +: 2];
          fields_reg.trig <= merged[`CFD_POS_TRIG +: 4];
        end
        `CFD_OFS_MPX: begin
          fields_reg.delay <= merged[`CFD_POS_DELAY +: 2];
          fields_reg.supp <= merged[`CFD_POS_SUPP +: 3];
        end
        default: fields_reg <= fields_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apply at period start; a write in the tick cycle stays pending
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      setting_reg <= decode(FIELDS_RST);
      strobe_reg <= 1'b0;
    end else if (tick) begin
      setting_reg <= decode(fields_reg);
      strobe_reg <= 1'b1;
    end else begin
      strobe_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pending_reg <= 1'b0;
    end else if (wr_take && ({address[7:2], 2'b00} != `CFD_OFS_STATUS)) begin
      pending_reg <= 1'b1;
    end else if (tick) begin
      pending_reg <= 1'b0;
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign setting = setting_reg;
  assign setting_strobe = strobe_reg;

endmodule
`default_nettype wire

/* File: bench/cfd_top_props.sv */
// Purpose: bus handshake and decoded setting checks
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every cfd_top instance
`timescale 1ns/10ps
`default_nettype none

module cfd_top_props (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // decoded constants
  input wire cfd_pkg::cfd_setting_s setting,
  input wire logic setting_strobe
);
  import cfd_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_bus_accept: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not accepted after one wait cycle");
  a_bus_idle: assert property (waitrequest && !read && !write |=> waitrequest)
    else $error("accept without a request");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("accept cycle longer than one clock");
  a_read_upper: assert property (!waitrequest |-> readdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_setting_hold: assert property (!setting_strobe |-> $stable(setting))
    else $error("setting changed without strobe");
  a_strobe_period: assert property (setting_strobe |-> ##65 setting_strobe)
    else $error("strobe spacing not one period");
  a_strobe_gap: assert property (setting_strobe |=> !setting_strobe [*8])
    else $error("strobe longer than one cycle");
  a_blank_enable: assert property (setting.blank_enable == (setting.blank_trigger != 7'h0))
    else $error("blanking enable does not follow trigger");
  a_stretch_len: assert property (setting.stretch_valid == (setting.pulse_len != 3'h0) && setting.stretch == (setting.stretch_valid ? setting.pulse_len - 3'h1 : 3'h0))
    else $error("stretch not pulse length minus one");
  a_length_odd: assert property (setting.blank_len[0] && setting.blank_len >= 4'h9)
    else $error("blanking length out of set");
  a_delay_range: assert property (setting.multiplex_blanking_delay >= 3'h2 && setting.multiplex_blanking_delay <= 3'h5)
    else $error("multiplex delay out of range");
endmodule

bind cfd_top cfd_top_props cfd_top_props_inst (.clock(clock), .resetn(resetn),
  .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .setting(setting), .setting_strobe(setting_strobe));

`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the field decoder
// Assumes: 20 MHz clock, Avalon-MM master driven at rising edges
// Notes: expected settings decoded here from the field tables
`timescale 1ns/10ps
`default_nettype none
`include "cfd_map.svh"

module testbench;
  import cfd_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  cfd_setting_s setting;
  logic setting_strobe;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  cfd_fields_s fld;
  logic [7:0] pll_tab [16] = '{8'd93, 8'd99, 8'd106, 8'd113, 8'd121, 8'd126,
    8'd132, 8'd137, 8'd143, 8'd148, 8'd154, 8'd159, 8'd165, 8'd170, 8'd176,
    8'd181};
  logic [10:0] mv_tab [8] = '{11'd410, 11'd493, 11'd587, 11'd700, 11'd833,
    11'd1000, 11'd1188, 11'd1387};
  logic [9:0] dev_tab [4] = '{10'd430, 10'd485, 10'd580, 10'd650};
  logic [6:0] trig_tab [16] = '{7'd0, 7'd2, 7'd3, 7'd4, 7'd5, 7'd6, 7'd8,
    7'd10, 7'd13, 7'd16, 7'd20, 7'd26, 7'd32, 7'd40, 7'd52, 7'd64};

  always #25 clock = ~clock;

  cfd_top cfd_top_inst (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .setting(setting), .setting_strobe(setting_strobe));

  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic cfd_setting_s dec(input cfd_fields_s f);
    cfd_setting_s s;
    s.pll_factor = pll_tab[f.pll_div];
    s.frac_a_half = {1'b0, ~f.frac_a[3], f.frac_a[2:0]} + 5'd12;
    s.frac_b_half = {1'b0, ~f.frac_b[3], f.frac_b[2:0]} + 5'd12;
    s.mpx_full_mv = mv_tab[f.sens_mpx];
    s.rds_full_mv = mv_tab[f.sens_rds];
    s.dev_limit_100hz = dev_tab[f.dev];
    s.blank_len = 4'd9 + {1'b0, f.len, 1'b0};
    s.blank_ofs = $signed({1'b0, f.ofs}) - 3'sd2;
    s.blank_enable = f.trig != 4'h0;
    s.blank_trigger = trig_tab[f.trig];
    s.multiplex_blanking_delay = {1'b0, ~f.delay[1], f.delay[0]} + 3'd2;
    s.pulse_len = f.supp ^ 3'b101;
    s.stretch_valid = s.pulse_len != 3'h0;
    s.stretch = s.stretch_valid ? s.pulse_len - 3'd1 : 3'd0;
    return s;
  endfunction

  function automatic logic [31:0] words(input cfd_fields_s f, input int r);
    case (r)
      0: return {16'h0, f.turbo, f.pll_div, 11'h0};
      1: return {24'h0, f.frac_b, f.frac_a};
      2: return {25'h0, f.sens_rds, f.sens_mpx, 1'b0};
      3: return {17'h0, f.dev, 5'h0, f.len, f.ofs, f.trig};
      default: return {21'h0, f.delay, f.supp, 6'h0};
    endcase
  endfunction

  task automatic check(input string name, input logic [79:0] seen,
                       input logic [79:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clock);
    address <= a;
    writedata <= {16'hffff, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) n_fail++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, 4'hf, q);
    check(n, q, e);
  endtask

  task automatic wait_strobe;
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (setting_strobe !== 1'b1 && k < 100);
    if (k >= 100) n_fail++;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    fld = '{`CFD_RST_TURBO, `CFD_RST_PLL_DIV, `CFD_RST_FRAC_A,
      `CFD_RST_FRAC_B, `CFD_RST_SENS_MPX, `CFD_RST_SENS_RDS, `CFD_RST_DEV,
      `CFD_RST_LEN, `CFD_RST_OFS, `CFD_RST_TRIG, `CFD_RST_DELAY,
      `CFD_RST_SUPP};
    @(negedge clock);
    check("default", setting, dec(fld));
    for (int r = 0; r < 5; r++) rdc("reset reg", 8'(r * 4), words(fld, r));
    rdc("status", `CFD_OFS_STATUS, 32'h9a00);
  endtask

  task automatic t_sweep;
    cfd_fields_s old;
    logic [3:0] j;
    for (int i = 0; i < 16; i++) begin
      old = fld;
      j = 4'(i);
      fld = '{1'b0, j, j, ~j, j[2:0], ~j[2:0], j[1:0], j[3:2], ~j[1:0], j,
        j[2:1], j[2:0]};
      wait_strobe();
      for (int r = 0; r < 5; r++) wr(8'(r * 4), 16'(words(fld, r)));
      check("held", setting, dec(old));
      rdc("pending", `CFD_OFS_STATUS, {16'h0, pll_tab[old.pll_div], 8'h01});
      wait_strobe();
      check("setting", setting, dec(fld));
      rdc("applied", `CFD_OFS_STATUS, {16'h0, pll_tab[j], 8'h00});
      for (int r = 0; r < 5; r++) rdc("reg", 8'(r * 4), words(fld, r));
    end
  endtask

  task automatic t_refused;
    logic [31:0] q;
    wr(8'h20, 16'hffff);
    rdc("unmapped", 8'h20, 32'h0);
    wr(`CFD_OFS_STATUS, 16'hffff);
    bus(1'b1, `CFD_OFS_LEVEL, 16'hffff, 4'b0010, q);
    fld.dev = 2'h3;
    for (int r = 0; r < 5; r++) rdc("lanes", 8'(r * 4), words(fld, r));
    wait_strobe();
    check("lane setting", setting, dec(fld));
    rdc("status ro", `CFD_OFS_STATUS, {16'h0, pll_tab[fld.pll_div], 8'h00});
  endtask

  task automatic t_reset;
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_defaults();
    t_sweep();
    t_refused();
    t_reset();
    t_defaults();
    give_verdict();
  end
endmodule

`default_nettype wire
